// ===== hw/csr_core_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) Indirect port access goes to the memory address held in its pointer.
// (RL2) Memory pointers are real registers, read and written like ordinary data.
// (RL3) Port 0 indirect accesses always land in sector 0.
// (RL4) Ports 1 and 2 reach any sector: high pointer byte sector, low byte location.
// (RL5) Extended direct access takes a full address, upper part sector, low byte location.
// (RL6) Bank bit clear selects bank 0, set selects bank 1 for jumps and calls.
// (RL7) Upper seven bits of the bank register always read zero.
// (RL8) Writing the program counter low byte jumps within the page, adding a dummy cycle.
// (RL9) Table read fetches at table pointers; high byte to result register, low to destination.
// (RL10) Software writes never change power-down or timeout flags.
// (RL11) Power-down flag cleared by power-up and watchdog clear, set by sleep.
// (RL12) Timeout flag cleared by power-up, watchdog clear or sleep, set by timeout.
// (RL13) Carry set on add carry or subtract no-borrow; rotate through carry updates it.
// (RL14) Half carry set on low nibble carry, or no nibble borrow in subtraction.
// (RL15) Zero flag set when the result is zero, cleared otherwise.
// (RL16) Overflow set when carry into top bit differs from carry out.
// (RL17) Signed compare flag is overflow XOR result top bit.
// (RL18) Plain subtracts copy the zero flag into the chained zero flag.
// (RL19) Borrow subtracts AND the chained zero flag with the current zero result.
// (RL20) Other instructions leave the chained zero flag alone.
// (RL21) Interrupts and calls do not save the flag register automatically.
// (RL22) Register to register moves must pass through the working accumulator.
// (RL23) Indirect port locations store nothing: read zero, writes ignored.
// (RL24) Reset clears timeout, power-down and bank bit; arithmetic flags unspecified.
module csr_core_regs import csr_pkg::*; #(
    parameter int unsigned SEC_W = 1,
    parameter int unsigned TGT_W = 12,
    parameter int unsigned PW = 16
) (
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Core data access, full data-memory address.
    input wire logic acc_rd,
    input wire logic acc_wr,
    input wire logic [SEC_W+DW-1:0] acc_addr,
    input wire logic [DW-1:0] acc_wdata,
    output logic [DW-1:0] acc_rdata,
    output logic acc_rvalid,
    // General data memory.
    output logic [SEC_W+DW-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [DW-1:0] mem_wdata,
    input wire logic [DW-1:0] mem_rdata,
    // Program flow.
    input wire logic [DW-1:0] pc_low,
    output logic pcl_load,
    output logic [DW-1:0] pcl_value,
    output logic dummy_cycle,
    input wire logic branch_req,
    input wire logic [TGT_W-1:0] branch_target,
    output logic branch_valid,
    output logic [TGT_W:0] branch_addr,
    // Table read from program memory.
    input wire logic tbl_req,
    output logic [2*DW-1:0] prog_addr,
    input wire logic [PW-1:0] prog_rdata,
    output logic [DW-1:0] tbl_low,
    output logic tbl_done,
    // Arithmetic unit report.
    input wire logic alu_valid,
    input wire csr_op_t alu_op,
    input wire logic [DW-1:0] alu_a,
    input wire logic [DW-1:0] alu_b,
    input wire logic [DW-1:0] logic_result,
    input wire logic rot_carry,
    // System events.
    input wire logic watchdog_clear_instruction_instr,
    input wire logic sleep_instr,
    input wire logic wdt_timeout,
    // Flag view.
    output logic [DW-1:0] flags
);

    localparam int unsigned AW = SEC_W + DW;
    localparam logic [SEC_W-1:0] SEC_ZERO = '0;

    csr_flag_if fl ();

    logic [DW-1:0] ptr0_q;
    logic [DW-1:0] ptr1l_q;
    logic [DW-1:0] ptr1h_q;
    logic [DW-1:0] ptr2l_q;
    logic [DW-1:0] ptr2h_q;
    logic [DW-1:0] accum_q;
    logic [DW-1:0] table_pointer_low_q;
    logic [DW-1:0] table_pointer_high_q;
    logic [DW-1:0] table_result_high_q;
    logic bank_q;
    logic [DW-1:0] rdata_q;
    logic rvalid_q;
    logic pcl_load_q;
    logic [DW-1:0] pcl_value_q;
    logic dummy_q;
    logic branch_valid_q;
    logic [TGT_W:0] branch_addr_q;
    logic [DW-1:0] tbl_low_q;
    logic tbl_done_q;

    logic [DW-1:0] req_low;
    logic req_sec0;
    logic [AW-1:0] eff_addr;
    logic [DW-1:0] eff_low;
    logic eff_is_sfr;
    logic eff_is_port;
    logic int_wr;
    logic [DW-1:0] int_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Address resolution. A port location swaps in its pointer before decoding,
    // so a pointer aimed at another core register reaches that register too.
    always_comb begin
        req_low = acc_addr[DW-1:0];
        req_sec0 = (acc_addr[AW-1:DW] == SEC_ZERO);
        eff_addr = acc_addr; // RL5
        if (req_sec0) begin
            unique case (req_low)
                ADDR_IND0: eff_addr = {SEC_ZERO, ptr0_q}; // RL3
                ADDR_IND1: eff_addr = {ptr1h_q[SEC_W-1:0], ptr1l_q}; // RL4
                ADDR_IND2: eff_addr = {ptr2h_q[SEC_W-1:0], ptr2l_q}; // RL4
                default: eff_addr = acc_addr;
            endcase
        end
        eff_low = eff_addr[DW-1:0];
        eff_is_sfr = (eff_addr[AW-1:DW] == SEC_ZERO) && (eff_low <= ADDR_LAST);
        // A pointer that targets a port location finds no storage there.
        eff_is_port = eff_is_sfr && ((eff_low == ADDR_IND0) || (eff_low == ADDR_IND1)
            || (eff_low == ADDR_IND2)); // RL23
        int_wr = acc_wr && eff_is_sfr;
    end

    // Memory side; the address always goes out, but only accesses outside the core registers raise mem_rd or mem_wr.
    assign mem_addr = eff_addr; // RL1
    assign mem_rd = acc_rd && !eff_is_sfr; // RL1
    assign mem_wr = acc_wr && !eff_is_sfr; // RL1
    assign mem_wdata = acc_wdata;

    // Read mux of the core registers.
    always_comb begin
        int_rdata = BYTE_ZERO;
        unique case (eff_low)
            ADDR_PTR0: int_rdata = ptr0_q; // RL2
            ADDR_PTR1L: int_rdata = ptr1l_q; // RL2
            ADDR_PTR1H: int_rdata = ptr1h_q; // RL2
            ADDR_PTR2L: int_rdata = ptr2l_q; // RL2
            ADDR_PTR2H: int_rdata = ptr2h_q; // RL2
            ADDR_ACC: int_rdata = accum_q;
            ADDR_PCL: int_rdata = pc_low;
            ADDR_TABLE_POINTER_LOW: int_rdata = table_pointer_low_q;
            ADDR_TABLE_POINTER_HIGH: int_rdata = table_pointer_high_q;
            ADDR_TABLE_RESULT_HIGH: int_rdata = table_result_high_q;
            ADDR_FLAGS: int_rdata = fl.flags;
            ADDR_PBS: int_rdata = {{(DW-1){1'b0}}, bank_q}; // RL7
            default: int_rdata = BYTE_ZERO; // RL23
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data is registered; memory data is taken in the request cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= BYTE_ZERO;
            rvalid_q <= 1'b0;
        end else if (ce) begin
            rvalid_q <= acc_rd;
            if (acc_rd) begin
                rdata_q <= eff_is_sfr ? int_rdata : mem_rdata; // RL1
            end
        end
    end

    // Memory pointers, each a plain writable byte.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr0_q <= BYTE_ZERO;
            ptr1l_q <= BYTE_ZERO;
            ptr1h_q <= BYTE_ZERO;
            ptr2l_q <= BYTE_ZERO;
            ptr2h_q <= BYTE_ZERO;
        end else if (ce && int_wr) begin
            unique case (eff_low)
                ADDR_PTR0: ptr0_q <= acc_wdata; // RL2
                ADDR_PTR1L: ptr1l_q <= acc_wdata; // RL2
                ADDR_PTR1H: ptr1h_q <= acc_wdata; // RL2
                ADDR_PTR2L: ptr2l_q <= acc_wdata; // RL2
                ADDR_PTR2H: ptr2h_q <= acc_wdata; // RL2
                default: ;
            endcase
        end
    end

    // The working accumulator; there is no path from one register to another
    // except through it, which keeps every move a read then a write.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accum_q <= BYTE_ZERO;
        end else if (ce && int_wr && eff_low == ADDR_ACC) begin
            accum_q <= acc_wdata; // RL22
        end
    end

    // Bank select holds one bit; the rest of the byte is dropped on write.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bank_q <= BANK_RST; // RL24
        end else if (ce && int_wr && eff_low == ADDR_PBS) begin
            bank_q <= acc_wdata[0]; // RL7
        end
    end

    // Branch address carries the bank bit above the in-bank target.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            branch_valid_q <= 1'b0;
            branch_addr_q <= '0;
        end else if (ce) begin
            branch_valid_q <= branch_req;
            if (branch_req) begin
                branch_addr_q <= {bank_q, branch_target}; // RL6
            end
        end
    end

    // Program counter low byte load; the sequencer keeps the page bits, and the
    // prefetched word is discarded in the dummy cycle that follows.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pcl_load_q <= 1'b0;
            pcl_value_q <= BYTE_ZERO;
            dummy_q <= 1'b0;
        end else if (ce) begin
            pcl_load_q <= int_wr && (eff_low == ADDR_PCL); // RL8
            dummy_q <= pcl_load_q; // RL8
            if (int_wr && eff_low == ADDR_PCL) begin
                pcl_value_q <= acc_wdata; // RL8
            end
        end
    end

    // Table pointers; a write to the table result register is ignored.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            table_pointer_low_q <= BYTE_ZERO;
            table_pointer_high_q <= BYTE_ZERO;
        end else if (ce && int_wr) begin
            if (eff_low == ADDR_TABLE_POINTER_LOW) begin
                table_pointer_low_q <= acc_wdata;
            end
            if (eff_low == ADDR_TABLE_POINTER_HIGH) begin
                table_pointer_high_q <= acc_wdata;
            end
        end
    end

    // Table read. Program memory answers in the same cycle, a limitation a
    // synchronous memory would need one extra stage to meet.
    assign prog_addr = {table_pointer_high_q, table_pointer_low_q}; // RL9
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            table_result_high_q <= BYTE_ZERO;
            tbl_low_q <= BYTE_ZERO;
            tbl_done_q <= 1'b0;
        end else if (ce) begin
            tbl_done_q <= tbl_req;
            if (tbl_req) begin
                table_result_high_q <= DW'(prog_rdata[PW-1:DW]); // RL9
                tbl_low_q <= prog_rdata[DW-1:0]; // RL9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flag traffic. Nothing here pushes flags anywhere on a call or interrupt.
    assign fl.sw_wr = int_wr && (eff_low == ADDR_FLAGS); // RL10
    assign fl.sw_data = acc_wdata;
    assign fl.alu_valid = alu_valid;
    assign fl.alu_op = alu_op;
    assign fl.alu_a = alu_a;
    assign fl.alu_b = alu_b;
    assign fl.logic_result = logic_result;
    assign fl.rot_carry = rot_carry;
    assign fl.watchdog_clear_instruction = watchdog_clear_instruction_instr;
    assign fl.sleep = sleep_instr;
    assign fl.wdt_to = wdt_timeout;

    csr_flag_unit u_flags (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .fl(fl)
    );

    // Outputs.
    assign acc_rdata = rdata_q;
    assign acc_rvalid = rvalid_q;
    assign pcl_load = pcl_load_q;
    assign pcl_value = pcl_value_q;
    assign dummy_cycle = dummy_q;
    assign branch_valid = branch_valid_q;
    assign branch_addr = branch_addr_q;
    assign tbl_low = tbl_low_q;
    assign tbl_done = tbl_done_q;
    assign flags = fl.flags; // RL21

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_pcl_write;
        acc_wr && eff_is_sfr && (eff_low == ADDR_PCL);
    endsequence
    sequence s_load_then_dummy;
        pcl_load_q && (pcl_value_q == $past(acc_wdata)) ##1 dummy_q;
    endsequence

    a_pcl_dummy_cycle: assert property (@(posedge clk) disable iff (rst || !ce) // RL8
        s_pcl_write |=> s_load_then_dummy)
        else $error("program counter load lacks its dummy cycle");
    a_port0_sector0: assert property (@(posedge clk) disable iff (rst) // RL3
        (req_sec0 && req_low == ADDR_IND0 && (acc_rd || acc_wr))
        |-> (mem_addr[AW-1:DW] == SEC_ZERO && mem_addr[DW-1:0] == ptr0_q))
        else $error("port 0 access left sector 0");
    a_port1_any_sector: assert property (@(posedge clk) disable iff (rst) // RL4
        (req_sec0 && req_low == ADDR_IND1 && acc_wr && !eff_is_sfr)
        |-> (mem_wr && mem_addr == {ptr1h_q[SEC_W-1:0], ptr1l_q}))
        else $error("port 1 access missed its pointer pair");
    a_port_reads_zero: assert property (@(posedge clk) disable iff (rst) // RL23
        (ce && acc_rd && eff_is_port) |=> (acc_rvalid && acc_rdata == BYTE_ZERO))
        else $error("port location read returned data");
    a_bank_upper_zero: assert property (@(posedge clk) disable iff (rst) // RL7
        (ce && acc_rd && eff_is_sfr && eff_low == ADDR_PBS)
        |=> (acc_rdata[DW-1:1] == '0 && acc_rdata[0] == $past(bank_q)))
        else $error("bank register upper bits not zero");
    a_branch_bank: assert property (@(posedge clk) disable iff (rst) // RL6
        (ce && branch_req) |=> (branch_valid && branch_addr[TGT_W] == $past(bank_q)))
        else $error("branch did not use the selected bank");
    a_table_split: assert property (@(posedge clk) disable iff (rst) // RL9
        (ce && tbl_req) |=> (tbl_done && tbl_low == $past(prog_rdata[DW-1:0])
        && table_result_high_q == DW'($past(prog_rdata[PW-1:DW]))))
        else $error("table read bytes misplaced");
    a_ptr_readback: assert property (@(posedge clk) disable iff (rst) // RL2
        (ce && int_wr && eff_low == ADDR_PTR0) |=> (ptr0_q == $past(acc_wdata)))
        else $error("pointer did not store its write");

endmodule

// ===== hw/csr_pkg.sv
package csr_pkg;

    // Data path width of the core.
    localparam int unsigned DW = 8;
    localparam int unsigned NIB = 4;

    // Printed special register locations inside sector 0.
    localparam logic [7:0] ADDR_IND0 = 8'h00;
    localparam logic [7:0] ADDR_PTR0 = 8'h01;
    localparam logic [7:0] ADDR_IND1 = 8'h02;
    localparam logic [7:0] ADDR_PTR1L = 8'h03;
    localparam logic [7:0] ADDR_PTR1H = 8'h04;
    localparam logic [7:0] ADDR_ACC = 8'h05;
    localparam logic [7:0] ADDR_PCL = 8'h06;
    localparam logic [7:0] ADDR_TABLE_POINTER_LOW = 8'h07;
    localparam logic [7:0] ADDR_TABLE_RESULT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_TABLE_POINTER_HIGH = 8'h09;
    localparam logic [7:0] ADDR_FLAGS = 8'h0a;
    localparam logic [7:0] ADDR_PBS = 8'h0b;
    localparam logic [7:0] ADDR_IND2 = 8'h0c;
    localparam logic [7:0] ADDR_PTR2L = 8'h0d;
    localparam logic [7:0] ADDR_PTR2H = 8'h0e;
    localparam logic [7:0] ADDR_LAST = ADDR_PTR2H;

    // Field positions of the core flag register.
    localparam int unsigned FLAG_SC = 7;
    localparam int unsigned FLAG_CZ = 6;
    localparam int unsigned FLAG_TO = 5;
    localparam int unsigned FLAG_PD = 4;
    localparam int unsigned FLAG_OV = 3;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_HC = 1;
    localparam int unsigned FLAG_C = 0;

    // Bits that software may write in the flag register.
    localparam logic [7:0] FLAGS_SW_MASK = 8'hcf;

    // Reset values.
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam logic BANK_RST = 1'b0;

    // Operation classes reported by the arithmetic unit.
    typedef enum logic [2:0] {
        CSR_OP_NONE = 3'h0,
        CSR_OP_ADD = 3'h1,
        CSR_OP_ADC = 3'h3,
        CSR_OP_SUB = 3'h2,
        CSR_OP_SBC = 3'h6,
        CSR_OP_LOGIC = 3'h7,
        CSR_OP_ROTC = 3'h5
    } csr_op_t;

endpackage

// ===== hw/csr_flag_if.sv
`timescale 1ns/1ps
interface csr_flag_if import csr_pkg::*; ();
    logic sw_wr;
    logic [DW-1:0] sw_data;
    logic alu_valid;
    csr_op_t alu_op;
    logic [DW-1:0] alu_a;
    logic [DW-1:0] alu_b;
    logic [DW-1:0] logic_result;
    logic rot_carry;
    logic watchdog_clear_instruction;
    logic sleep;
    logic wdt_to;
    logic [DW-1:0] flags;

    modport regs (
        output sw_wr, sw_data, alu_valid, alu_op, alu_a, alu_b, logic_result,
        output rot_carry, watchdog_clear_instruction, sleep, wdt_to,
        input flags
    );
    modport unit (
        input sw_wr, sw_data, alu_valid, alu_op, alu_a, alu_b, logic_result,
        input rot_carry, watchdog_clear_instruction, sleep, wdt_to,
        output flags
    );
endinterface

// ===== hw/csr_flag_unit.sv
`timescale 1ns/1ps
module csr_flag_unit import csr_pkg::*; (
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Flag traffic from the register file.
    csr_flag_if.unit fl
);

    localparam int unsigned SUM_W = DW + 1;

    logic [DW-1:0] arith_q;
    logic to_q;
    logic pd_q;
    logic [DW-1:0] b_eff;
    logic cin;
    logic is_sub;
    logic is_arith;
    logic [SUM_W-1:0] sum;
    logic [NIB:0] lo_sum;
    logic ovf;
    logic zero;

    ////////////////////////////////////////////////////////////////////////////////
    // Adder that sets the flags; subtraction adds the complement, so carry is no-borrow.
    always_comb begin
        is_sub = (fl.alu_op == CSR_OP_SUB) || (fl.alu_op == CSR_OP_SBC);
        is_arith = is_sub || (fl.alu_op == CSR_OP_ADD) || (fl.alu_op == CSR_OP_ADC);
        b_eff = is_sub ? ~fl.alu_b : fl.alu_b;
        unique case (fl.alu_op)
            CSR_OP_SUB: cin = 1'b1;
            CSR_OP_ADC, CSR_OP_SBC: cin = arith_q[FLAG_C];
            default: cin = 1'b0;
        endcase
        sum = SUM_W'(fl.alu_a) + SUM_W'(b_eff) + SUM_W'(cin);
        lo_sum = (NIB+1)'(fl.alu_a[NIB-1:0]) + (NIB+1)'(b_eff[NIB-1:0]) + (NIB+1)'(cin);
        // Carry into the top bit is recovered from the top bit sum.
        ovf = (fl.alu_a[DW-1] ^ b_eff[DW-1] ^ sum[DW-1]) ^ sum[DW]; // RL16
        zero = is_arith ? (sum[DW-1:0] == BYTE_ZERO) : (fl.logic_result == BYTE_ZERO);
    end

    // Arithmetic flags: an operation in the same cycle wins over a software write.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arith_q <= BYTE_ZERO; // RL24
        end else if (ce) begin
            if (fl.sw_wr) begin
                arith_q <= fl.sw_data & FLAGS_SW_MASK; // RL10
            end
            if (fl.alu_valid && is_arith) begin
                arith_q[FLAG_C] <= sum[DW]; // RL13
                arith_q[FLAG_HC] <= lo_sum[NIB]; // RL14
                arith_q[FLAG_Z] <= zero; // RL15
                arith_q[FLAG_OV] <= ovf; // RL16
                arith_q[FLAG_SC] <= ovf ^ sum[DW-1]; // RL17
                if (fl.alu_op == CSR_OP_SUB) begin
                    arith_q[FLAG_CZ] <= zero; // RL18
                end else if (fl.alu_op == CSR_OP_SBC) begin
                    arith_q[FLAG_CZ] <= arith_q[FLAG_CZ] & zero; // RL19
                end
            end else if (fl.alu_valid && fl.alu_op == CSR_OP_LOGIC) begin
                arith_q[FLAG_Z] <= zero; // RL15
            end else if (fl.alu_valid && fl.alu_op == CSR_OP_ROTC) begin
                arith_q[FLAG_C] <= fl.rot_carry; // RL13
            end
        end
    end

    // Power-down flag; sleeping is the set and wins over a watchdog clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_q <= FLAG_RST; // RL24
        end else if (ce) begin
            if (fl.sleep) begin
                pd_q <= 1'b1; // RL11
            end else if (fl.watchdog_clear_instruction) begin
                pd_q <= 1'b0; // RL11
            end
        end
    end

    // Timeout flag; a timeout in the cycle of a clear is kept.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            to_q <= FLAG_RST; // RL24
        end else if (ce) begin
            if (fl.wdt_to) begin
                to_q <= 1'b1; // RL12
            end else if (fl.watchdog_clear_instruction || fl.sleep) begin
                to_q <= 1'b0; // RL12
            end
        end
    end

    // Read view; the system bits come only from their own flip-flops.
    always_comb begin
        fl.flags = arith_q;
        fl.flags[FLAG_TO] = to_q;
        fl.flags[FLAG_PD] = pd_q;
    end

    a_sys_bits_kept: assert property (@(posedge clk) disable iff (rst) // RL10
        (ce && fl.sw_wr && !fl.sleep && !fl.watchdog_clear_instruction && !fl.wdt_to)
        |=> ($stable(to_q) && $stable(pd_q)))
        else $error("software write altered a system flag");
    a_sleep_sets_pd: assert property (@(posedge clk) disable iff (rst) // RL11
        (ce && fl.sleep && !fl.wdt_to) |=> (fl.flags[FLAG_PD] && !fl.flags[FLAG_TO]))
        else $error("sleep did not set power-down and clear timeout");
    a_cz_chain: assert property (@(posedge clk) disable iff (rst) // RL19
        (ce && fl.alu_valid && fl.alu_op == CSR_OP_SBC && !zero) |=> !arith_q[FLAG_CZ])
        else $error("chained zero not cleared by nonzero borrow subtract");
    a_cz_hold: assert property (@(posedge clk) disable iff (rst) // RL20
        (ce && fl.alu_valid && !is_sub && !fl.sw_wr) |=> $stable(arith_q[FLAG_CZ]))
        else $error("chained zero changed by another instruction");

endmodule

// ===== verification/test_cpu_core_special_registers.sv
`timescale 1ns/1ps
module test_cpu_core_special_registers import csr_pkg::*;;
    typedef struct {csr_op_t op; logic [7:0] a, b, lr; logic rc; logic [7:0] e;} csr_tb_row_t;
    logic clk, rst, ce, acc_rd, acc_wr, acc_rvalid, mem_rd, mem_wr, pcl_load, dummy_cycle;
    logic branch_req, branch_valid, tbl_req, tbl_done, alu_valid, rot_carry;
    logic watchdog_clear_instruction_instr, sleep_instr, wdt_timeout;
    logic [8:0] acc_addr, mem_addr;
    logic [7:0] acc_wdata, acc_rdata, mem_wdata, mem_rdata, pc_low, pcl_value, tbl_low;
    logic [7:0] alu_a, alu_b, logic_result, flags;
    logic [11:0] branch_target;
    logic [12:0] branch_addr;
    logic [15:0] prog_addr, prog_rdata;
    csr_op_t alu_op;
    int n_mismatch, checks, cyc;
    // Each row starts from the flags the previous row left, so carry-in and CZ chain.
    csr_tb_row_t rows[8] = '{
        '{CSR_OP_ADD, 8'h7f, 8'h01, 8'h00, 1'b0, 8'h0a},
        '{CSR_OP_SUB, 8'h05, 8'h05, 8'h00, 1'b0, 8'h47},
        '{CSR_OP_SBC, 8'h10, 8'h10, 8'h00, 1'b0, 8'h47},
        '{CSR_OP_SBC, 8'h00, 8'h01, 8'h00, 1'b0, 8'h80},
        '{CSR_OP_ADC, 8'h01, 8'hff, 8'h00, 1'b0, 8'h07},
        '{CSR_OP_LOGIC, 8'h00, 8'h00, 8'h55, 1'b0, 8'h03},
        '{CSR_OP_ROTC, 8'h00, 8'h00, 8'h00, 1'b0, 8'h02},
        '{CSR_OP_SUB, 8'h80, 8'h01, 8'h00, 1'b0, 8'h89}};

    csr_core_regs dut_u (.clk(clk), .rst(rst), .ce(ce), .acc_rd(acc_rd), .acc_wr(acc_wr),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .acc_rvalid(acc_rvalid), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .pc_low(pc_low), .pcl_load(pcl_load),
        .pcl_value(pcl_value), .dummy_cycle(dummy_cycle), .branch_req(branch_req),
        .branch_target(branch_target), .branch_valid(branch_valid),
        .branch_addr(branch_addr), .tbl_req(tbl_req), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata), .tbl_low(tbl_low), .tbl_done(tbl_done),
        .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
        .logic_result(logic_result), .rot_carry(rot_carry), .watchdog_clear_instruction_instr(watchdog_clear_instruction_instr),
        .sleep_instr(sleep_instr), .wdt_timeout(wdt_timeout), .flags(flags));

    ////////////////////////////////////////////////////////////////////////////
    // Free-running 10 MHz clock.
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    // A hung handshake must not stall the run forever.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task end_sim;
        if (n_mismatch == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task cmp(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // One core access; a nonzero ma is the expected {strobe, memory address}.
    task xfer(input logic w, input logic [8:0] a, input logic [7:0] d, input logic [7:0] e,
              input logic [9:0] ma);
        @(posedge clk);
        #1;
        acc_wr = w;
        acc_rd = !w;
        acc_addr = a;
        acc_wdata = d;
        #1;
        if (ma != 0) cmp({mem_rd | mem_wr, mem_addr}, ma);
        @(posedge clk);
        #1;
        acc_wr = 0;
        acc_rd = 0;
        if (!w) begin
            cmp({acc_rvalid, acc_rdata}, {1'b1, e});
        end
    endtask

    task automatic pulse(ref logic s);
        @(posedge clk);
        #1;
        s = 1;
        @(posedge clk);
        #1;
        s = 0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: flag table first, then the register and event cases.
    initial begin
        {rst, ce, mem_rdata, pc_low, prog_rdata} = {2'b11, 8'h5a, 8'h9c, 16'habcd};
        {acc_rd, acc_wr, acc_addr, acc_wdata, branch_req, tbl_req, alu_valid} = 0;
        {alu_a, alu_b, logic_result, rot_carry, watchdog_clear_instruction_instr, sleep_instr, wdt_timeout} = 0;
        {branch_target, n_mismatch, checks, cyc} = {12'h123, 96'h0};
        alu_op = CSR_OP_NONE;
        repeat (2) @(posedge clk);
        #1;
        rst = 0;
        cmp(flags, 8'h00);
        xfer(1, 9'h00a, 8'h00, 0, 0);
        foreach (rows[i]) begin
            @(posedge clk);
            #1;
            {alu_valid, alu_a, alu_b} = {1'b1, rows[i].a, rows[i].b};
            alu_op = rows[i].op;
            {logic_result, rot_carry} = {rows[i].lr, rows[i].rc};
            @(posedge clk);
            #1;
            alu_valid = 0;
            cmp(flags, rows[i].e);
        end
        xfer(1, 9'h00a, 8'hff, 0, 0);
        cmp(flags, 8'hcf);
        pulse(sleep_instr);
        cmp(flags, 8'hdf);
        pulse(wdt_timeout);
        cmp(flags, 8'hff);
        xfer(1, 9'h00a, 8'h00, 0, 0);
        cmp(flags, 8'h30);
        pulse(sleep_instr);
        cmp(flags, 8'h10);
        pulse(wdt_timeout);
        pulse(watchdog_clear_instruction_instr);
        cmp(flags, 8'h00);
        xfer(1, 9'h00b, 8'hff, 0, 0);
        xfer(0, 9'h00b, 0, 8'h01, 0);
        pulse(branch_req);
        cmp({branch_valid, branch_addr}, 14'h3123);
        xfer(1, 9'h001, 8'h40, 0, 0);
        xfer(0, 9'h001, 0, 8'h40, 0);
        xfer(0, 9'h000, 0, 8'h5a, 10'h240);
        xfer(1, 9'h004, 8'h01, 0, 0);
        xfer(1, 9'h003, 8'h40, 0, 0);
        xfer(1, 9'h002, 8'h77, 0, 10'h340);
        cmp(mem_wdata, 8'h77);
        xfer(0, 9'h1f0, 0, 8'h5a, 10'h3f0);
        xfer(1, 9'h001, 8'h00, 0, 0);
        xfer(1, 9'h000, 8'h66, 0, 0);
        xfer(0, 9'h000, 0, 8'h00, 0);
        xfer(0, 9'h006, 0, 8'h9c, 0);
        xfer(1, 9'h006, 8'h33, 0, 0);
        cmp({pcl_load, pcl_value}, 9'h133);
        @(posedge clk);
        #1;
        cmp({pcl_load, dummy_cycle}, 2'b01);
        xfer(1, 9'h007, 8'h34, 0, 0);
        xfer(1, 9'h009, 8'h12, 0, 0);
        cmp(prog_addr, 16'h1234);
        pulse(tbl_req);
        cmp({tbl_done, tbl_low}, 9'h1cd);
        xfer(0, 9'h008, 0, 8'hab, 0);
        // A frozen core must ignore the sleep event.
        ce = 0;
        pulse(sleep_instr);
        cmp(flags, 8'h00);
        ce = 1;
        pulse(sleep_instr);
        cmp(flags, 8'h10);
        @(posedge clk);
        #1;
        rst = 1;
        @(posedge clk);
        #1;
        cmp(flags, 8'h00);
        rst = 0;
        xfer(0, 9'h00b, 0, 8'h00, 0);
        end_sim();
    end
endmodule
